// file: rtl/servo_fault_manager.sv
// Purpose: grades, latches and clears drive faults and warnings, keeps history
// Assumes: detectors give one-cycle event pulses and level cause flags
// Notes: registers are reached over a classic wishbone slave, one ack cycle
`timescale 1ns/1ps
module servo_fault_manager (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [fault_pkg::ADR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic event_valid_in,
   input wire logic event_warn_in,
   input wire logic [fault_pkg::CODE_W-1:0] event_code_in,
   input wire logic fault_cause_in,
   input wire logic warn_cause_in,
   input wire logic fault_clear_in,
   input wire logic servo_enable_in,
   input wire logic [fault_pkg::STATUS_W-1:0] drive_status_in,
   input wire logic pending_stop_change_in,
   output logic stop_out,
   output logic run_out,
   output logic fault_active_out,
   output logic warning_active_out,
   output logic apply_stop_change_out
);
   fault_pkg::active_s fault_r;
   fault_pkg::active_s fault_nxt;
   fault_pkg::active_s warn_r;
   fault_pkg::active_s warn_nxt;
   fault_pkg::drive_state_e state_r;
   fault_pkg::drive_state_e state_nxt;
   fault_pkg::category_e evt_cat;
   fault_pkg::hist_s fault_hist [fault_pkg::HIST_DEPTH];
   fault_pkg::hist_s warn_hist [fault_pkg::HIST_DEPTH];
   fault_pkg::hist_s hist_entry;
   logic clear_cmd_r;
   logic enable_d_r;
   logic wr_stb;
   logic cmd_clear;
   logic clear_req;
   logic evt_fault;
   logic evt_warn;
   logic fault_clr_ok;
   logic warn_clr_ok;
   logic [31:0] rd_data;
   logic [3:0] hist_idx;

   // a write is taken on the edge that raises ack, so each access acts once
   assign wr_stb = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
   assign cmd_clear = wr_stb && (wb_adr_in == fault_pkg::ADR_CLEAR) && wb_sel_in[0]
                      && wb_dat_in[fault_pkg::CLEAR_BIT];
   // the clear input is a level: it keeps requesting while it stays active
   assign clear_req = cmd_clear || fault_clear_in;

   assign evt_fault = event_valid_in && !event_warn_in;
   assign evt_warn = event_valid_in && event_warn_in;
   assign evt_cat = fault_pkg::fault_category(event_code_in);

   // category 1 never clears; 2 and 3 need enable off and the cause gone
   assign fault_clr_ok = clear_req && fault_r.valid && (fault_r.cat != fault_pkg::cat_1)
                         && !servo_enable_in && !fault_cause_in;
   assign warn_clr_ok = clear_req && warn_r.valid && !warn_cause_in;

   // next active fault: a new event wins over a clear in the same cycle
   always_comb begin
      fault_nxt = fault_r;
      if (evt_fault && (!fault_r.valid || fault_clr_ok || evt_cat < fault_r.cat)) begin
         fault_nxt.valid = 1'b1;
         fault_nxt.cat = evt_cat;
         fault_nxt.code = event_code_in;
      end else if (fault_clr_ok) begin
         fault_nxt.valid = 1'b0;
      end
   end

   // next active warning: the newest warning is the one shown
   always_comb begin
      warn_nxt = warn_r;
      if (evt_warn) begin
         warn_nxt.valid = 1'b1;
         warn_nxt.cat = fault_pkg::cat_4;
         warn_nxt.code = event_code_in;
      end else if (warn_clr_ok) begin
         warn_nxt.valid = 1'b0;
      end
   end

   // drive state: warnings never stop, a cleared fault falls back to ready or run
   always_comb begin
      if (fault_nxt.valid) begin
         state_nxt = fault_pkg::st_fault;
      end else if (servo_enable_in) begin
         state_nxt = fault_pkg::st_run;
      end else begin
         state_nxt = fault_pkg::st_ready;
      end
   end

   // latched fault and warning
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         fault_r <= '0;
         warn_r <= '0;
      end else begin
         fault_r <= fault_nxt;
         warn_r <= warn_nxt;
      end
   end

   // state and status outputs, all registered from the same next values
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_r <= fault_pkg::st_ready;
         stop_out <= 1'b0;
         run_out <= 1'b0;
         fault_active_out <= 1'b0;
         warning_active_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
         stop_out <= (state_nxt == fault_pkg::st_fault);
         run_out <= (state_nxt == fault_pkg::st_run);
         fault_active_out <= fault_nxt.valid;
         warning_active_out <= warn_nxt.valid;
      end
   end

   // pending stop-type settings apply only on an enable drop, never on a clear
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         enable_d_r <= 1'b0;
         apply_stop_change_out <= 1'b0;
      end else begin
         enable_d_r <= servo_enable_in;
         apply_stop_change_out <= enable_d_r && !servo_enable_in
                                  && pending_stop_change_in;
      end
   end

   // clear command register keeps the last written value for read-back
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         clear_cmd_r <= fault_pkg::CLEAR_RESET;
      end else if (wr_stb && wb_adr_in == fault_pkg::ADR_CLEAR && wb_sel_in[0]) begin
         clear_cmd_r <= wb_dat_in[fault_pkg::CLEAR_BIT];
      end
   end

   // history entry carries the drive status seen when the event arrived
   assign hist_entry = '{valid: 1'b1, status: drive_status_in, code: event_code_in};

   event_history #(
      .DEPTH(fault_pkg::HIST_DEPTH)
   ) u_fault_hist (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .push_in(evt_fault),
      .entry_in(hist_entry),
      .entries_out(fault_hist)
   );

   event_history #(
      .DEPTH(fault_pkg::HIST_DEPTH)
   ) u_warn_hist (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .push_in(evt_warn),
      .entry_in(hist_entry),
      .entries_out(warn_hist)
   );

   // read mux; history words 0..4 are faults, 5..9 warnings, newest first
   assign hist_idx = wb_adr_in[5:2];
   always_comb begin
      rd_data = 32'h0000_0000;
      if (wb_adr_in == fault_pkg::ADR_CLEAR) begin
         rd_data[fault_pkg::CLEAR_BIT] = clear_cmd_r;
      end else if (wb_adr_in == fault_pkg::ADR_FAULT) begin
         rd_data[fault_pkg::MON_VALID_BIT] = fault_r.valid;
         rd_data[fault_pkg::MON_CAT_LSB +: 2] = fault_r.cat;
         rd_data[fault_pkg::MON_CODE_LSB +: fault_pkg::CODE_W] = fault_r.code;
      end else if (wb_adr_in == fault_pkg::ADR_WARN) begin
         rd_data[fault_pkg::MON_VALID_BIT] = warn_r.valid;
         rd_data[fault_pkg::MON_CAT_LSB +: 2] = warn_r.cat;
         rd_data[fault_pkg::MON_CODE_LSB +: fault_pkg::CODE_W] = warn_r.code;
      end else if (wb_adr_in == fault_pkg::ADR_STATE) begin
         rd_data[1:0] = state_r;
         rd_data[fault_pkg::STATE_ENABLE_BIT] = servo_enable_in;
      end else if (wb_adr_in[7:6] == fault_pkg::ADR_HIST_BASE[7:6] && wb_adr_in[1:0] == 2'h0
                   && hist_idx < fault_pkg::HIST_WORDS) begin
         for (int i = 0; i < fault_pkg::HIST_DEPTH; i++) begin
            if (hist_idx == 4'(i)) begin
               rd_data[fault_pkg::HIST_STATUS_LSB +: fault_pkg::STATUS_W] =
                  fault_hist[i].status;
               rd_data[fault_pkg::HIST_VALID_BIT] = fault_hist[i].valid;
               rd_data[fault_pkg::CODE_W-1:0] = fault_hist[i].code;
            end
            if (hist_idx == 4'(i + fault_pkg::HIST_DEPTH)) begin
               rd_data[fault_pkg::HIST_STATUS_LSB +: fault_pkg::STATUS_W] =
                  warn_hist[i].status;
               rd_data[fault_pkg::HIST_VALID_BIT] = warn_hist[i].valid;
               rd_data[fault_pkg::CODE_W-1:0] = warn_hist[i].code;
            end
         end
      end
   end

   // bus answer: ack one cycle after the request, dropped the next cycle;
   // unmapped addresses still ack and read zero so a master never hangs
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
         wb_dat_out <= (wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out) ? rd_data
                       : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   cat1_keep_a: assert property (
      fault_r.valid && fault_r.cat == fault_pkg::cat_1 |=> fault_r.valid
         && fault_r.cat == fault_pkg::cat_1)
      else $error("category one fault was cleared");
   enable_gate_a: assert property (
      fault_r.valid && servo_enable_in |=> fault_r.valid && stop_out)
      else $error("fault cleared while servo enable was on");
   cause_hold_a: assert property (
      fault_r.valid && fault_cause_in |=> fault_active_out)
      else $error("fault cleared while its cause was present");
   warn_clear_a: assert property (
      warn_r.valid && clear_req && !warn_cause_in && !evt_warn && servo_enable_in
         |=> !warning_active_out)
      else $error("warning not cleared by clear request");
   no_request_a: assert property (
      fault_r.valid && !clear_req |=> fault_r.valid[*2] or (fault_r.valid ##1 clear_req))
      else $error("fault dropped without a clear request");
   run_direct_a: assert property (
      !fault_r.valid && !evt_fault && servo_enable_in |=> run_out && !stop_out)
      else $error("drive did not run with enable on and no fault latched");
   warn_runs_a: assert property (
      evt_warn && !fault_r.valid && !evt_fault && servo_enable_in
         |=> run_out && warning_active_out && !stop_out)
      else $error("warning stopped the drive");
   fault_stops_a: assert property (
      evt_fault |=> stop_out && fault_active_out ##1 stop_out || !fault_active_out)
      else $error("fault event did not stop the drive");
   worst_shown_a: assert property (
      fault_r.valid && evt_fault && evt_cat >= fault_r.cat && !fault_clr_ok
         |=> fault_r.cat == $past(fault_r.cat) && fault_r.code == $past(fault_r.code))
      else $error("less severe fault replaced the shown fault");
   hist_keep_a: assert property (
      fault_clr_ok && !evt_fault |=> fault_hist[0] == $past(fault_hist[0]))
      else $error("clearing changed the fault history");
   ack_pulse_a: assert property (
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
      else $error("bus ack not a single cycle one cycle after request");
   sel_gate_a: assert property (
      wr_stb && !wb_sel_in[0] |=> clear_cmd_r == $past(clear_cmd_r))
      else $error("clear register changed by a write without its byte");
   cmd_clears_a: assert property (
      cmd_clear && fault_r.valid && fault_r.cat != fault_pkg::cat_1 && !servo_enable_in
         && !fault_cause_in && !evt_fault |=> !fault_active_out)
      else $error("clear command write did not clear a clearable fault");
   hist_push_a: assert property (
      evt_fault |=> fault_hist[0].valid && fault_hist[0].code == $past(event_code_in)
         && fault_hist[0].status == $past(drive_status_in))
      else $error("fault event not recorded in history");
   warn_shown_a: assert property (
      evt_warn |=> warn_r.valid && warn_r.cat == fault_pkg::cat_4
         && warn_r.code == $past(event_code_in))
      else $error("newest warning not shown");
endmodule : servo_fault_manager

// file: common/fault_pkg.sv
// Purpose: shared constants, types and code grading for the servo fault manager
// Assumes: fault codes arrive as the plain decimal number of the code (Er.22 -> 22)
// Notes: register offsets are byte addresses of 32-bit words on the classic bus
package fault_pkg;
   localparam int CODE_W = 8;
   localparam int STATUS_W = 16;
   localparam int HIST_DEPTH = 5;
   localparam int ADR_W = 8;
   // register byte offsets
   localparam logic [7:0] ADR_CLEAR = 8'h00;
   localparam logic [7:0] ADR_FAULT = 8'h04;
   localparam logic [7:0] ADR_WARN = 8'h08;
   localparam logic [7:0] ADR_STATE = 8'h0C;
   localparam logic [7:0] ADR_HIST_BASE = 8'h40;
   localparam logic [3:0] HIST_WORDS = 4'hA;
   // field positions
   localparam int CLEAR_BIT = 0;
   localparam int MON_CODE_LSB = 0;
   localparam int MON_CAT_LSB = 8;
   localparam int MON_VALID_BIT = 16;
   localparam int HIST_VALID_BIT = 8;
   localparam int HIST_STATUS_LSB = 16;
   localparam int STATE_ENABLE_BIT = 2;
   // reset values
   localparam logic CLEAR_RESET = 1'h0;

   // category 1 is the most severe; a lower value means more severe
   typedef enum logic [1:0] {cat_1, cat_2, cat_3, cat_4} category_e;
   typedef enum logic [1:0] {st_ready, st_run, st_fault} drive_state_e;

   typedef struct packed {
      logic valid;
      category_e cat;
      logic [CODE_W-1:0] code;
   } active_s;

   typedef struct packed {
      logic valid;
      logic [STATUS_W-1:0] status;
      logic [CODE_W-1:0] code;
   } hist_s;

   // grade a fault code; codes outside the tables of categories 1 and 2 grade as 3
   function automatic category_e fault_category(input logic [CODE_W-1:0] code);
      category_e cat;
      cat = cat_3;
      if ((code >= 8'h01 && code <= 8'h07) || (code >= 8'h3C && code <= 8'h41)) begin
         cat = cat_1;
      end
      unique case (code)
         8'h14, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h20: cat = cat_1;
         8'h16, 8'h1B, 8'h1F: cat = cat_2;
         default: ;
      endcase
      return cat;
   endfunction : fault_category
endpackage : fault_pkg

// file: rtl/event_history.sv
// Purpose: keeps the last DEPTH events, newest at index 0
// Assumes: one push per clock at most
// Notes: entries are never erased by clearing, only pushed out by newer events
`timescale 1ns/1ps
module event_history #(
   parameter int DEPTH = fault_pkg::HIST_DEPTH
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic push_in,
   input wire fault_pkg::hist_s entry_in,
   output fault_pkg::hist_s entries_out [DEPTH]
);
   // shift register; the oldest entry falls off the end
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_slot
         always_ff @(posedge clk_in) begin
            if (!rst_b_in) begin
               entries_out[i] <= '0;
            end else if (push_in) begin
               if (i == 0) begin
                  entries_out[i] <= entry_in;
               end else begin
                  entries_out[i] <= entries_out[i-1];
               end
            end
         end
      end
   endgenerate
endmodule : event_history

// file: tb/host_model.sv
// Purpose: host side model driving the servo enable and the clear input
// Assumes: clear_req_in is a one-cycle request from the bench
// Notes: rude_in keeps enable on through a clear, to provoke a refusal
`timescale 1ns/1ps
module host_model (
   input wire logic clk_in,
   input wire logic run_req_in,
   input wire logic clear_req_in,
   input wire logic rude_in,
   output logic servo_enable_out = 1'h0,
   output logic fault_clear_out = 1'h0
);
   logic [1:0] phase_r = 2'h0;

   // enable off first, clear pulse next, enable back last; no motion is sent meanwhile
   always_ff @(posedge clk_in) begin
      if (clear_req_in) begin
         phase_r <= 2'h1;
         servo_enable_out <= run_req_in & rude_in;
         fault_clear_out <= 1'h0;
      end else if (phase_r == 2'h1) begin
         phase_r <= 2'h2;
         fault_clear_out <= 1'h1;
      end else begin
         phase_r <= 2'h0;
         fault_clear_out <= 1'h0;
         servo_enable_out <= run_req_in;
      end
   end
endmodule : host_model

// file: tb/servo_fault_manager_tb.sv
// Purpose: self-checking bench for the fault manager
// Assumes: one-cycle bus ack, status outputs settle one edge after their cause
// Notes: every scenario starts from a fresh reset
`timescale 1ns/1ps
module servo_fault_manager_tb;
   logic clk_in = 1'h0;
   logic rst_b_in = 1'h0;
   logic cyc = 1'h0;
   logic we = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [3:0] sel = 4'hF;
   logic [31:0] rdat;
   logic ev_v = 1'h0;
   logic ev_w = 1'h0;
   logic [7:0] ev_code = 8'h00;
   logic [15:0] status = 16'h0000;
   logic f_cause = 1'h0;
   logic w_cause = 1'h0;
   logic pend = 1'h0;
   logic run_req = 1'h0;
   logic clr_req = 1'h0;
   logic rude = 1'h0;
   logic seen_apply = 1'h0;
   logic [31:0] wb_dat;
   logic wb_ack, enable, fclr, stop, run, fact, wact, apply;
   wire [31:0] flg = {28'h0, stop, run, fact, wact};
   int n_mismatch = 0;
   int n_tests = 0;

   // free-running clock, 50 ns period
   always #25 clk_in = ~clk_in;

   // the stop-change pulse is one cycle wide, so keep a sticky copy
   always @(posedge clk_in) if (apply === 1'h1) seen_apply <= 1'h1;

   host_model host (.clk_in(clk_in), .run_req_in(run_req), .clear_req_in(clr_req),
      .rude_in(rude), .servo_enable_out(enable), .fault_clear_out(fclr));

   servo_fault_manager uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
      .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
      .wb_dat_in(wdat), .wb_dat_out(wb_dat), .wb_ack_out(wb_ack),
      .event_valid_in(ev_v), .event_warn_in(ev_w), .event_code_in(ev_code),
      .fault_cause_in(f_cause), .warn_cause_in(w_cause), .fault_clear_in(fclr),
      .servo_enable_in(enable), .drive_status_in(status),
      .pending_stop_change_in(pend), .stop_out(stop), .run_out(run),
      .fault_active_out(fact), .warning_active_out(wact),
      .apply_stop_change_out(apply));

   task automatic print_verdict();
      $display("counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // classic single cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
      int i;
      @(posedge clk_in);
      cyc <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (wb_ack !== 1'h1 && i < 20);
      rdat = wb_dat;
      cyc <= 1'h0;
      if (wb_ack !== 1'h1) begin
         n_mismatch++;
         print_verdict();
      end
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'h0, a, 32'h0);
      chk(rdat, e);
   endtask : rd

   task automatic do_reset();
      @(posedge clk_in);
      rst_b_in <= 1'h0;
      run_req <= 1'h0;
      pend <= 1'h0;
      repeat (20) @(posedge clk_in);
      rst_b_in <= 1'h1;
      @(posedge clk_in);
      #1;
   endtask : do_reset

   task automatic ev(input logic w, input logic [7:0] code);
      @(posedge clk_in);
      ev_v <= 1'h1;
      ev_w <= w;
      ev_code <= code;
      status <= {8'h00, code};
      @(posedge clk_in);
      ev_v <= 1'h0;
      #1;
   endtask : ev

   // host clear sequence plus the cause levels seen while it runs
   task automatic clr(input logic r, input logic fc, input logic wc);
      @(posedge clk_in);
      clr_req <= 1'h1;
      rude <= r;
      f_cause <= fc;
      w_cause <= wc;
      @(posedge clk_in);
      clr_req <= 1'h0;
      repeat (3) @(posedge clk_in);
      #1;
   endtask : clr

   task automatic t_reset();
      do_reset();
      chk(flg, 32'h0);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'hF0, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_grade();
      logic [7:0] codes [15] = '{8'h01, 8'h07, 8'h3C, 8'h41, 8'h14, 8'h18, 8'h1A,
         8'h1C, 8'h1E, 8'h20, 8'h16, 8'h1B, 8'h1F, 8'h15, 8'h21};
      logic [1:0] cat;
      for (int k = 0; k < 15; k++) begin
         cat = (k < 10) ? 2'h0 : (k < 13) ? 2'h1 : 2'h2;
         do_reset();
         ev(1'h0, codes[k]);
         chk(flg, 32'hA);
         rd(8'h04, {15'h0, 1'h1, 6'h0, cat, codes[k]});
      end
      $display("test grade done");
   endtask : t_grade

   task automatic t_cat1();
      do_reset();
      ev(1'h0, 8'h20);
      clr(1'h0, 1'h0, 1'h0);
      wb(1'h1, 8'h00, 32'h1);
      #1;
      chk(flg, 32'hA);
      rd(8'h0C, 32'h2);
      $display("test cat1 done");
   endtask : t_cat1

   task automatic t_cat2();
      do_reset();
      @(posedge clk_in);
      run_req <= 1'h1;
      ev(1'h0, 8'h16);
      clr(1'h1, 1'h0, 1'h0);
      chk(flg, 32'hA);
      clr(1'h0, 1'h1, 1'h0);
      chk(flg, 32'hA);
      clr(1'h0, 1'h0, 1'h0);
      chk(flg, 32'h4);
      rd(8'h0C, 32'h5);
      rd(8'h40, {8'h00, 8'h16, 7'h0, 1'h1, 8'h16});
      $display("test cat2 done");
   endtask : t_cat2

   task automatic t_warn();
      do_reset();
      @(posedge clk_in);
      run_req <= 1'h1;
      pend <= 1'h1;
      ev(1'h1, 8'h51);
      chk(flg, 32'h5);
      rd(8'h08, 32'h0001_0351);
      clr(1'h1, 1'h0, 1'h1);
      chk(flg, 32'h5);
      wb(1'h1, 8'h00, 32'h0);
      #1;
      chk(flg, 32'h5);
      seen_apply = 1'h0;
      clr(1'h1, 1'h0, 1'h0);
      chk(flg, 32'h4);
      chk(seen_apply, 32'h0);
      @(posedge clk_in);
      run_req <= 1'h0;
      repeat (3) @(posedge clk_in);
      #1;
      chk(seen_apply, 32'h1);
      rd(8'h54, {8'h00, 8'h51, 7'h0, 1'h1, 8'h51});
      $display("test warning done");
   endtask : t_warn

   task automatic t_cmd();
      do_reset();
      ev(1'h0, 8'h15);
      rd(8'h00, 32'h0);
      // a write without the low byte lane must neither clear nor store
      wb(1'h1, 8'h00, 32'h1, 4'hE);
      #1;
      chk(flg, 32'hA);
      rd(8'h00, 32'h0);
      wb(1'h1, 8'h00, 32'h1);
      #1;
      chk(flg, 32'h0);
      rd(8'h00, 32'h1);
      $display("test command done");
   endtask : t_cmd

   task automatic t_hist();
      logic [7:0] seq [6] = '{8'h21, 8'h22, 8'h16, 8'h23, 8'h24, 8'h25};
      logic [7:0] c;
      do_reset();
      for (int k = 0; k < 6; k++) ev(1'h0, seq[k]);
      ev(1'h1, 8'h52);
      rd(8'h04, 32'h0001_0116);
      for (int k = 0; k < 10; k++) begin
         c = (k < 5) ? seq[5-k] : (k == 5) ? 8'h52 : 8'h00;
         rd(8'h40 + 8'(4 * k), (c == 8'h00) ? 32'h0 : {8'h00, c, 7'h0, 1'h1, c});
      end
      $display("test history done");
   endtask : t_hist

   // main sequence
   initial begin
      t_reset();
      t_grade();
      t_cat1();
      t_cat2();
      t_warn();
      t_cmd();
      t_hist();
      print_verdict();
   end
endmodule : servo_fault_manager_tb
